//--- src/avsw_control.sv
// Serial control and status register block of the audio/video switch
`timescale 1ns/10ps
module avsw_control
   import avsw_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   // Serial bus pins, data line open drain
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n_out,
   input  wire logic       adr_select_in,
   // Sliced video for the sync detectors
   input  wire logic       tuner_video_input_level_in,
   input  wire logic       tuner_video_input_amp_ok_in,
   input  wire logic       first_luminance_output_level_in,
   input  wire logic       first_luminance_output_amp_ok_in,
   input  wire logic       first_composite_input_level_in,
   input  wire logic       first_composite_input_amp_ok_in,
   input  wire logic       second_luminance_output_level_in,
   input  wire logic       second_luminance_output_amp_ok_in,
   // Connector format levels and audio events
   input  wire logic [1:0] first_connector_format_input_in,
   input  wire logic [1:0] second_connector_format_input_in,
   input  wire logic [1:0] third_connector_format_input_in,
   input  wire logic       hw_mute_in,
   input  wire logic       zero_cross_in,
   // Video switch settings
   output logic [3:0]      first_composite_selector_out,
   output logic [3:0]      second_composite_selector_out,
   output logic            first_delay_enable_out,
   output logic            second_delay_enable_out,
   output logic [4:0]      delay_adjust_out,
   output logic [2:0]      first_luma_chroma_selector_out,
   output logic [2:0]      second_luma_chroma_selector_out,
   // Open-collector logic outputs, low enable pulls the pin low
   output logic            first_open_collector_output_oe_n_out,
   output logic            second_open_collector_output_oe_n_out,
   // Audio switch settings
   output logic [2:0]      first_audio_selector_out,
   output logic [2:0]      second_audio_selector_out,
   output logic [2:0]      channel3_audio_selector_out,
   output logic            zero_cross_gating_out,
   output logic [2:0]      channel3_coarse_volume_out,
   output logic [2:0]      channel3_fine_volume_out,
   output logic [1:0]      channel3_routing_out,
   output logic            channel3_mute_out,
   output logic            audio_mute_all_out
);

   typedef struct packed {
      avsw_i2c_state_t st;
      logic            scl_q;
      logic            sda_q;
      logic [3:0]      cnt;
      logic [7:0]      sh;
      logic            rw;
      logic [2:0]      ptr;
      logic            mack;
      logic            sda_oe_n;
      logic            por;
      logic [5:0][7:0] regs;
      logic [2:0]      coarse;
      logic [2:0]      fine;
      logic            mute;
      logic [9:0]      line_cnt;
      logic            line_tick;
      logic            hw_mute;
      logic [4:0]      mode;
   } avsw_ctl_state_t;

   avsw_ctl_state_t s_r;
   avsw_ctl_state_t s_nxt;
   logic            first_sync_detector_present;
   logic            second_sync_detector_present;
   logic            first_sync_detector_level;
   logic            first_sync_detector_amp;
   logic            second_sync_detector_level;
   logic            second_sync_detector_amp;
   logic [7:0]      status_byte;

   // Level codes above the narrow format are treated as narrow
   function automatic logic [4:0] fmt_weight(input logic [1:0] lvl);
      fmt_weight = (lvl == FMT_INTERNAL) ? 5'h00 : (lvl == FMT_WIDE) ? 5'h01 : {3'h0, FMT_NARROW};
   endfunction

   // base-three combination of the three format inputs
   function automatic logic [4:0] mode_code(input logic [1:0] m1, input logic [1:0] m2, input logic [1:0] m3);
      logic [4:0] w2;
      logic [4:0] w3;
      w2 = fmt_weight(m2);
      w3 = fmt_weight(m3);
      mode_code = fmt_weight(m1) + w2 + w2 + w2 + {w3[1:0], 3'h0} + w3;
   endfunction

   // detector source chosen by the sixth control byte
   always_comb begin
      if (s_r.regs[IDX_SYNC][BIT_FIRST_SYNC_DETECTOR_SRC]) begin
         first_sync_detector_level = tuner_video_input_level_in;
         first_sync_detector_amp   = tuner_video_input_amp_ok_in;
      end else begin
         first_sync_detector_level = first_luminance_output_level_in;
         first_sync_detector_amp   = first_luminance_output_amp_ok_in;
      end
      if (s_r.regs[IDX_SYNC][BIT_SECOND_SYNC_DETECTOR_SRC]) begin
         second_sync_detector_level = first_composite_input_level_in;
         second_sync_detector_amp   = first_composite_input_amp_ok_in;
      end else begin
         second_sync_detector_level = second_luminance_output_level_in;
         second_sync_detector_amp   = second_luminance_output_amp_ok_in;
      end
   end

   avsw_sync_detect u_first_sync_detector (
      .clk_in       (clk_in),
      .resetn_in    (resetn_in),
      .line_tick_in (s_r.line_tick),
      .amp_ok_in    (first_sync_detector_amp),
      .level_in     (first_sync_detector_level),
      .present_out  (first_sync_detector_present)
   );

   avsw_sync_detect u_second_sync_detector (
      .clk_in       (clk_in),
      .resetn_in    (resetn_in),
      .line_tick_in (s_r.line_tick),
      .amp_ok_in    (second_sync_detector_amp),
      .level_in     (second_sync_detector_level),
      .present_out  (second_sync_detector_present)
   );

   // status byte layout; flags high when sync present
   assign status_byte = {second_sync_detector_present, first_sync_detector_present, s_r.mode, s_r.por};

   always_comb begin
      logic scl_rise;
      logic scl_fall;
      logic start_c;
      logic stop_c;
      logic zc_ok;
      zc_ok    = !s_r.regs[IDX_AUDIO][BIT_HI] || zero_cross_in;
      scl_rise = scl_in & ~s_r.scl_q;
      scl_fall = ~scl_in & s_r.scl_q;
      start_c  = s_r.scl_q & scl_in & s_r.sda_q & ~sda_in;
      stop_c   = s_r.scl_q & scl_in & ~s_r.sda_q & sda_in;
      s_nxt       = s_r;
      s_nxt.scl_q = scl_in;
      s_nxt.sda_q = sda_in;

      if (start_c) begin
         s_nxt.st       = ST_ADDR;
         s_nxt.cnt      = 4'h0;
         s_nxt.sda_oe_n = 1'b1;
      end else if (stop_c) begin
         s_nxt.st       = ST_IDLE;
         s_nxt.sda_oe_n = 1'b1;
      end else begin
         unique case (s_r.st)
            ST_IDLE: begin
               s_nxt.sda_oe_n = 1'b1;
            end
            ST_ADDR, ST_WR: begin
               if (scl_rise) begin
                  s_nxt.sh  = {s_r.sh[6:0], sda_in};
                  s_nxt.cnt = s_r.cnt + 4'h1;
               end else if (scl_fall && s_r.cnt == BITS_PER_BYTE) begin
                  if (s_r.st == ST_ADDR) begin
                     // compare fixed bits and the select pin
                     if (s_r.sh[7:1] == {DEV_ADDR_HI, adr_select_in}) begin
                        s_nxt.rw       = s_r.sh[0];
                        s_nxt.ptr      = IDX_COMP;
                        s_nxt.st       = ST_AACK;
                        s_nxt.sda_oe_n = 1'b0;
                     end else begin
                        s_nxt.st = ST_IDLE;
                     end
                  // store in sequence, refuse past the last byte
                  end else if (s_r.ptr < NUM_CTRL) begin
                     if (s_r.ptr == IDX_SYNC) begin
                        s_nxt.regs[s_r.ptr] = s_r.sh & SYNC_BYTE_MASK;
                     end else begin
                        s_nxt.regs[s_r.ptr] = s_r.sh;
                     end
                     s_nxt.ptr      = s_r.ptr + 3'h1;
                     // first written byte clears the power-on flag
                     s_nxt.por      = 1'b0;
                     s_nxt.st       = ST_WACK;
                     s_nxt.sda_oe_n = 1'b0;
                  end else begin
                     s_nxt.st = ST_IDLE;
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  if (s_r.rw) begin
                     s_nxt.st       = ST_RD;
                     s_nxt.sda_oe_n = status_byte[7];
                     s_nxt.sh       = {status_byte[6:0], 1'b0};
                     s_nxt.cnt      = CNT_FIRST_TX;
                  end else begin
                     s_nxt.st       = ST_WR;
                     s_nxt.sda_oe_n = 1'b1;
                     s_nxt.cnt      = 4'h0;
                  end
               end
            end
            ST_WACK: begin
               if (scl_fall) begin
                  s_nxt.st       = ST_WR;
                  s_nxt.sda_oe_n = 1'b1;
                  s_nxt.cnt      = 4'h0;
               end
            end
            ST_RD: begin
               if (scl_fall) begin
                  if (s_r.cnt == BITS_PER_BYTE) begin
                     s_nxt.sda_oe_n = 1'b1;
                     s_nxt.st       = ST_RACK;
                  end else begin
                     s_nxt.sda_oe_n = s_r.sh[7];
                     s_nxt.sh       = {s_r.sh[6:0], 1'b0};
                     s_nxt.cnt      = s_r.cnt + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  s_nxt.mack = ~sda_in;
               end else if (scl_fall) begin
                  // Master ack repeats the status byte; nack ends the read
                  if (s_r.mack) begin
                     s_nxt.st       = ST_RD;
                     s_nxt.sda_oe_n = status_byte[7];
                     s_nxt.sh       = {status_byte[6:0], 1'b0};
                     s_nxt.cnt      = CNT_FIRST_TX;
                  end else begin
                     s_nxt.st = ST_IDLE;
                  end
               end
            end
            default: begin
               s_nxt.st       = ST_IDLE;
               s_nxt.sda_oe_n = 1'b1;
            end
         endcase
      end

      // volume and mute wait for a zero cross while gating is on
      if (zc_ok) begin
         s_nxt.coarse = s_r.regs[IDX_VOL][7:5];
         s_nxt.fine   = s_r.regs[IDX_VOL][4:2];
         s_nxt.mute   = s_r.regs[IDX_AUDIO][BIT_HI2];
      end

      // Line period divider shared by both detectors
      if (s_r.line_cnt == LINE_LAST) begin
         s_nxt.line_cnt  = 10'h000;
         s_nxt.line_tick = 1'b1;
      end else begin
         s_nxt.line_cnt  = s_r.line_cnt + 10'h001;
         s_nxt.line_tick = 1'b0;
      end

      s_nxt.hw_mute = hw_mute_in;
      s_nxt.mode    = mode_code(first_connector_format_input_in, second_connector_format_input_in,
                                third_connector_format_input_in);
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_r          <= '0;
         s_r.st       <= ST_IDLE;
         s_r.scl_q    <= 1'b1;
         s_r.sda_q    <= 1'b1;
         s_r.sda_oe_n <= 1'b1;
         s_r.por      <= 1'b1;
         s_r.regs     <= CTRL_RST;
         s_r.coarse   <= CTRL_RST[IDX_VOL][7:5];
         s_r.fine     <= CTRL_RST[IDX_VOL][4:2];
         s_r.mute     <= CTRL_RST[IDX_AUDIO][BIT_HI2];
      end else begin
         s_r <= s_nxt;
      end
   end

   // Open drain: the data line only ever pulls low
   assign sda_out      = 1'b0;
   assign sda_oe_n_out = s_r.sda_oe_n;

   // composite selectors from the first byte
   assign first_composite_selector_out  = s_r.regs[IDX_COMP][7:4];
   assign second_composite_selector_out = s_r.regs[IDX_COMP][3:0];
   // delay enables from the sixth byte upper bits
   assign first_delay_enable_out        = s_r.regs[IDX_SYNC][BIT_HI];
   assign second_delay_enable_out       = s_r.regs[IDX_SYNC][BIT_HI2];
   assign first_luma_chroma_selector_out  = s_r.regs[IDX_LOGIC][5:3];
   assign second_luma_chroma_selector_out = s_r.regs[IDX_LOGIC][2:0];
   // bit 0 sinks the pin, bit 1 leaves it open
   assign first_open_collector_output_oe_n_out  = s_r.regs[IDX_LOGIC][BIT_HI];
   assign second_open_collector_output_oe_n_out = s_r.regs[IDX_LOGIC][BIT_HI2];
   assign first_audio_selector_out  = s_r.regs[IDX_AUDIO][5:3];
   assign second_audio_selector_out = s_r.regs[IDX_AUDIO][2:0];
   assign zero_cross_gating_out     = s_r.regs[IDX_AUDIO][BIT_HI];
   // delay adjust, channel-3 source, volume and routing
   assign delay_adjust_out            = s_r.regs[IDX_DELAY][7:3];
   assign channel3_audio_selector_out = s_r.regs[IDX_DELAY][2:0];
   assign channel3_coarse_volume_out  = s_r.coarse;
   assign channel3_fine_volume_out    = s_r.fine;
   assign channel3_routing_out        = s_r.regs[IDX_VOL][1:0];
   assign channel3_mute_out  = s_r.mute | s_r.hw_mute;
   assign audio_mute_all_out = s_r.hw_mute;

endmodule // avsw_control

//--- include/avsw_pkg.sv
// Constants, reset values and state codes for the audio/video switch control block
package avsw_pkg;

   // Serial bus address: upper six bits fixed, seventh from the select pin
   localparam logic [5:0] DEV_ADDR_HI   = 6'h24;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] CNT_FIRST_TX  = 4'h1;
   localparam logic [2:0] NUM_CTRL      = 3'h6;

   // Control byte indices, in the order the master sends them
   localparam logic [2:0] IDX_COMP  = 3'h0;
   localparam logic [2:0] IDX_LOGIC = 3'h1;
   localparam logic [2:0] IDX_AUDIO = 3'h2;
   localparam logic [2:0] IDX_DELAY = 3'h3;
   localparam logic [2:0] IDX_VOL   = 3'h4;
   localparam logic [2:0] IDX_SYNC  = 3'h5;

   // Power-on contents of the six control bytes, first byte lowest
   localparam logic [5:0][7:0] CTRL_RST = {8'hf0, 8'hfc, 8'h87, 8'hff, 8'hff, 8'h99};
   // Sixth byte keeps only its upper half
   localparam logic [7:0] SYNC_BYTE_MASK = 8'hf0;

   // Bit positions within the control bytes, the two high ones shared by several bytes
   localparam int BIT_HI  = 7;
   localparam int BIT_HI2 = 6;
   localparam int BIT_FIRST_SYNC_DETECTOR_SRC = 5;
   localparam int BIT_SECOND_SYNC_DETECTOR_SRC = 4;

   // Connector format level codes per input
   localparam logic [1:0] FMT_INTERNAL = 2'h0;
   localparam logic [1:0] FMT_WIDE     = 2'h1;
   localparam logic [1:0] FMT_NARROW   = 2'h2;

   // Sync detector timing
   localparam int CLK_PERIOD_NS  = 100;
   localparam int LINE_PERIOD_NS = 64000;
   localparam int LINE_CYC_I     = LINE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int DUTY_ON_PCT    = 91;
   localparam int DUTY_OFF_PCT   = 84;
   localparam logic [9:0] LINE_CYC     = 10'(LINE_CYC_I);
   localparam logic [9:0] LINE_LAST    = 10'(LINE_CYC_I - 1);
   localparam logic [9:0] DUTY_ON_CYC  = 10'((LINE_CYC_I * DUTY_ON_PCT) / 100);
   localparam logic [9:0] DUTY_OFF_CYC = 10'((LINE_CYC_I * DUTY_OFF_PCT) / 100);
   localparam logic [3:0] HOLD_LINES   = 4'he;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_AACK = 7'h04,
      ST_WR   = 7'h08,
      ST_WACK = 7'h10,
      ST_RD   = 7'h20,
      ST_RACK = 7'h40
   } avsw_i2c_state_t;

endpackage

//--- src/avsw_sync_detect.sv
// One sync detector: amplitude gate, duty discrimination with hysteresis, line hold
`timescale 1ns/10ps
module avsw_sync_detect
   import avsw_pkg::*;
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic resetn_in,
   // Line timing and sliced video
   input  wire logic line_tick_in,
   input  wire logic amp_ok_in,
   input  wire logic level_in,
   // Result
   output logic      present_out
);

   typedef struct packed {
      logic [9:0] cnt_hi;
      logic       amp_fail;
      logic       raw;
      logic [3:0] hold;
      logic       present;
   } avsw_sd_state_t;

   avsw_sd_state_t s_r;
   avsw_sd_state_t s_nxt;

   always_comb begin
      logic raw_v;
      raw_v = s_r.raw;
      s_nxt = s_r;
      if (line_tick_in) begin
         if (s_r.amp_fail || !amp_ok_in) begin
            raw_v = 1'b0;
         end else if (s_r.cnt_hi > DUTY_ON_CYC) begin
            raw_v = 1'b1;
         end else if (s_r.cnt_hi <= DUTY_OFF_CYC) begin
            raw_v = 1'b0;
         end
         s_nxt.raw = raw_v;
         if (raw_v != s_r.present) begin
            if (s_r.hold == HOLD_LINES - 4'h1) begin
               s_nxt.present = raw_v;
               s_nxt.hold    = 4'h0;
            end else begin
               s_nxt.hold = s_r.hold + 4'h1;
            end
         end else begin
            s_nxt.hold = 4'h0;
         end
         s_nxt.cnt_hi   = {9'h000, level_in};
         s_nxt.amp_fail = !amp_ok_in;
      end else begin
         s_nxt.cnt_hi   = s_r.cnt_hi + {9'h000, level_in};
         s_nxt.amp_fail = s_r.amp_fail | !amp_ok_in;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign present_out = s_r.present;

endmodule // avsw_sync_detect

//--- testbench/avsw_control_checker.sv
// Port-level assertions for the audio/video switch control block
`timescale 1ns/10ps
module avsw_control_checker
   import avsw_pkg::*;
(
   // Clock, reset and bus
   input wire logic       clk_in,
   input wire logic       resetn_in,
   input wire logic       scl_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_n_out,
   // Audio events
   input wire logic       hw_mute_in,
   input wire logic       zero_cross_in,
   // Settings
   input wire logic [3:0] first_composite_selector_out,
   input wire logic [2:0] first_luma_chroma_selector_out,
   input wire logic       first_open_collector_output_oe_n_out,
   input wire logic       zero_cross_gating_out,
   input wire logic [2:0] channel3_coarse_volume_out,
   input wire logic [1:0] channel3_routing_out,
   input wire logic       channel3_mute_out,
   input wire logic       audio_mute_all_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   AST_SDA_VALUE_LOW: assert property (sda_out == 1'b0)
      else $error("data line value not low");
   AST_SDA_SCL_LOW: assert property ($changed(sda_oe_n_out) |-> !scl_in)
      else $error("data line moved while clock high");
   AST_HWMUTE_SET: assert property (hw_mute_in |=> audio_mute_all_out && channel3_mute_out)
      else $error("hardware mute not applied");
   AST_HWMUTE_CLR: assert property (!hw_mute_in |=> !audio_mute_all_out)
      else $error("hardware mute stuck");
   AST_OC_AT_ACK: assert property ($changed(first_open_collector_output_oe_n_out) |-> !sda_oe_n_out)
      else $error("open collector changed outside a byte store");
   AST_COMP_AT_ACK: assert property ($changed(first_composite_selector_out) |-> !sda_oe_n_out)
      else $error("composite selector changed outside a byte store");
   AST_LUMA_AT_ACK: assert property ($changed(first_luma_chroma_selector_out) |-> !sda_oe_n_out)
      else $error("luma selector changed outside a byte store");
   AST_ROUTE_AT_ACK: assert property ($changed(channel3_routing_out) |-> !sda_oe_n_out)
      else $error("routing changed outside a byte store");
   AST_ZCD_GATE: assert property (($changed(channel3_coarse_volume_out) && $past(zero_cross_gating_out))
      |-> $past(zero_cross_in))
      else $error("gated volume applied without zero cross");

   cover property (!sda_oe_n_out ##1 scl_in);
   cover property (zero_cross_gating_out && zero_cross_in);
   cover property (hw_mute_in ##1 audio_mute_all_out);
endmodule // avsw_control_checker

bind avsw_control avsw_control_checker u_chk (
   .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe_n_out(sda_oe_n_out), .hw_mute_in(hw_mute_in), .zero_cross_in(zero_cross_in),
   .first_composite_selector_out(first_composite_selector_out),
   .first_luma_chroma_selector_out(first_luma_chroma_selector_out),
   .first_open_collector_output_oe_n_out(first_open_collector_output_oe_n_out),
   .zero_cross_gating_out(zero_cross_gating_out),
   .channel3_coarse_volume_out(channel3_coarse_volume_out),
   .channel3_routing_out(channel3_routing_out), .channel3_mute_out(channel3_mute_out),
   .audio_mute_all_out(audio_mute_all_out));

//--- testbench/avsw_i2c_master.sv
// Serial bus master model that drives the clock and data lines
`timescale 1ns/10ps
module avsw_i2c_master (
   // Clock and bus lines, data released high
   input  wire logic clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic start_c();
      sda_out = 1'b1;
      wait_clk(2);
      scl_out = 1'b1;
      wait_clk(4);
      sda_out = 1'b0;
      wait_clk(4);
      scl_out = 1'b0;
      wait_clk(2);
   endtask
   task automatic stop_c();
      sda_out = 1'b0;
      wait_clk(2);
      scl_out = 1'b1;
      wait_clk(4);
      sda_out = 1'b1;
      wait_clk(4);
   endtask
   // data moves only with clock low
   task automatic bit_io(input logic b, output logic r);
      sda_out = b;
      wait_clk(2);
      scl_out = 1'b1;
      wait_clk(2);
      r = sda_in;
      wait_clk(2);
      scl_out = 1'b0;
      wait_clk(2);
   endtask
   // most significant bit first, ninth bit is acknowledge
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic recv_byte(output logic [7:0] d, input logic last);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule // avsw_i2c_master

//--- testbench/tb.sv
// Self-checking bench for the audio/video switch control block
`timescale 1ns/10ps
module tb;
   import avsw_pkg::*;
   logic       clk_in, resetn_in, scl, m_sda, sda_w, sda_d, sda_oe_n, adr_sel, hw_mute, zc;
   logic       amp1, amp2, lvl1, lvl2, de1, de2, oc1, oc2, zcg, m3, mall;
   logic [1:0] fmt1, fmt2, fmt3, rte;
   logic [3:0] comp1, comp2;
   logic [4:0] dly;
   logic [2:0] yc1, yc2, a1, a2, a3, crs, fin;
   logic [7:0] wb [7];
   logic [7:0] st;
   int         err_count, compares, hi1, hi2, lcnt;

   // Open-drain wire with pull-up
   assign sda_w = m_sda & (sda_oe_n | sda_d);

   avsw_i2c_master bm (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(m_sda));

   avsw_control DUT (
      .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_d),
      .sda_oe_n_out(sda_oe_n), .adr_select_in(adr_sel),
      .tuner_video_input_level_in(lvl1), .tuner_video_input_amp_ok_in(amp1),
      // Luminance outputs carry the other detector's video, so a source switch is visible
      .first_luminance_output_level_in(lvl2), .first_luminance_output_amp_ok_in(amp2),
      .first_composite_input_level_in(lvl2), .first_composite_input_amp_ok_in(amp2),
      .second_luminance_output_level_in(lvl1), .second_luminance_output_amp_ok_in(amp1),
      .first_connector_format_input_in(fmt1), .second_connector_format_input_in(fmt2),
      .third_connector_format_input_in(fmt3), .hw_mute_in(hw_mute), .zero_cross_in(zc),
      .first_composite_selector_out(comp1), .second_composite_selector_out(comp2),
      .first_delay_enable_out(de1), .second_delay_enable_out(de2), .delay_adjust_out(dly),
      .first_luma_chroma_selector_out(yc1), .second_luma_chroma_selector_out(yc2),
      .first_open_collector_output_oe_n_out(oc1), .second_open_collector_output_oe_n_out(oc2),
      .first_audio_selector_out(a1), .second_audio_selector_out(a2),
      .channel3_audio_selector_out(a3), .zero_cross_gating_out(zcg),
      .channel3_coarse_volume_out(crs), .channel3_fine_volume_out(fin),
      .channel3_routing_out(rte), .channel3_mute_out(m3), .audio_mute_all_out(mall));

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // Sliced video: hi cycles of each 640-cycle line sit above the sync tip
   always @(posedge clk_in) begin
      #1;
      lcnt = (lcnt + 1) % 640;
      lvl1 = (lcnt < hi1);
      lvl2 = (lcnt < hi2);
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input int n, input logic aok);
      logic ak;
      bm.start_c();
      bm.send_byte(a, ak);
      chk({7'h00, ak}, {7'h00, aok});
      for (int i = 0; i < n && aok; i++) begin
         bm.send_byte(wb[i], ak);
         chk({7'h00, ak}, {7'h00, i < 6});
      end
      bm.stop_c();
   endtask

   task automatic rd(output logic [7:0] d);
      logic ak;
      bm.start_c();
      bm.send_byte(8'h91, ak);
      chk({7'h00, ak}, 8'h01);
      bm.recv_byte(d, 1'b1);
      bm.stop_c();
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (70000) @(posedge clk_in);
      err_count++;
      finish_test();
   end

   initial begin
      {resetn_in, adr_sel, hw_mute, zc, amp1, amp2} = 6'h00;
      hi1 = 0;
      hi2 = 0;
      lcnt = 0;
      err_count = 0;
      compares = 0;
      {fmt1, fmt2, fmt3} = {2'h2, 2'h1, 2'h0};
      repeat (10) @(posedge clk_in);
      #1;
      resetn_in = 1'b1;
      bm.wait_clk(2);
      chk({comp1, comp2}, 8'h99);
      chk({oc1, oc2, yc1, yc2}, 8'hff);
      chk({zcg, m3, a1, a2}, 8'hff);
      chk({dly, a3}, 8'h87);
      chk({crs, fin, rte}, 8'hfc);
      chk({de1, de2, 6'h00}, 8'hc0);
      rd(st);
      chk(st, 8'h0b);
      $display("test reset_status done");
      wb = '{8'h12, 8'h40, 8'h0d, 8'h83, 8'h4a, 8'h7f, 8'h00};
      wr(8'h92, 1, 1'b0);
      wr(8'h90, 7, 1'b1);
      chk({comp1, comp2}, 8'h12);
      chk({oc1, oc2, yc1, yc2}, 8'h40);
      chk({zcg, m3, a1, a2}, 8'h0d);
      chk({dly, a3}, 8'h83);
      chk({crs, fin, rte}, 8'h4a);
      chk({de1, de2, 6'h00}, 8'h40);
      rd(st);
      chk(st, 8'h0a);
      $display("test write_all done");
      adr_sel = 1'b1;
      wb[0] = 8'h99;
      wr(8'h90, 1, 1'b0);
      wr(8'h92, 1, 1'b1);
      chk({comp1, comp2}, 8'h99);
      chk({oc1, oc2, yc1, yc2}, 8'h40);
      adr_sel = 1'b0;
      $display("test address_select done");
      hw_mute = 1'b1;
      bm.wait_clk(2);
      chk({6'h00, mall, m3}, 8'h03);
      hw_mute = 1'b0;
      bm.wait_clk(2);
      chk({6'h00, mall, m3}, 8'h00);
      $display("test hw_mute done");
      wb = '{8'h12, 8'h40, 8'hcd, 8'h83, 8'he6, 8'h7f, 8'h00};
      wr(8'h90, 5, 1'b1);
      chk({crs, fin, rte}, 8'h4a);
      chk({zcg, m3, a1, a2}, 8'h8d);
      zc = 1'b1;
      bm.wait_clk(1);
      zc = 1'b0;
      bm.wait_clk(2);
      chk({crs, fin, rte}, 8'he6);
      chk({zcg, m3, a1, a2}, 8'hcd);
      $display("test zero_cross done");
      hi1 = 608;
      hi2 = 563;
      {amp1, amp2} = 2'h3;
      bm.wait_clk(6400);
      rd(st);
      chk(st, 8'h0a);
      bm.wait_clk(6400);
      rd(st);
      chk(st, 8'h4a);
      amp1 = 1'b0;
      bm.wait_clk(12800);
      rd(st);
      chk(st, 8'h0a);
      $display("test sync_detect done");
      // Luminance sources: second flag sees the strong line, first stays in the band
      {fmt1, fmt2, fmt3} = {2'h1, 2'h2, 2'h1};
      wb[5] = 8'hc0;
      wr(8'h90, 6, 1'b1);
      chk({de1, de2, 6'h00}, 8'hc0);
      amp1 = 1'b1;
      bm.wait_clk(12800);
      rd(st);
      chk(st, 8'ha0);
      $display("test luma_source done");
      finish_test();
   end
endmodule // tb
